// >>> hw/iss_ctrl.sv
// Standby controller: light idle and deep stop entry, wake-up, clock gates.
// Assumes the CPU and interrupt controller report requests synchronously.
// Operation
// - Trigger with deep bit 0 enters idle
// - Idle keeps oscillator, gates CPU and peripherals
// - Internal data held during standby
// - Sub or external clocked peripherals keep running
// - Idle exit resumes with no wait
// - NMI, unmasked irqs or reset wake
// - Idle release returns to normal operation
// - Lower priority request only wakes
// - Higher priority or NMI wakes and acknowledges
// - Branch choice depends on NMI and enable
// - Reset release equals normal reset
// - Trigger with deep bit 1 enters stop
// - Stop halts main oscillator, subclock runs
// - Stop exit waits stabilization interval
// - Interval uses programmed setting, reset default
// - Port pins hold status in standby
// - 8-bit timers run only on external input
// - Clocked serial runs on external clock
// - First UART on external clock, others halt
// - Watch timer idle rules with subclock
// - Subclock-sourced timers keep running
`default_nettype none
module iss_ctrl (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire iss_pkg::iss_wake_t wake_in,
	input wire logic in_service,
	input wire logic [2:0] service_prio,
	input wire logic int_enable,
	output logic wake_ack,
	output logic wake_branch,
	output logic wake_pulse,
	output logic main_osc_en,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic intc_clk_en,
	output iss_pkg::iss_keep_t keep_en,
	output logic port_hold,
	output logic [1:0] mode_state
);
	iss_pkg::iss_state_t state_r;
	logic [7:0] mode_r;
	logic [2:0] stab_sel_r;
	logic [7:0] clksel_r;
	logic [iss_pkg::STAB_W-1:0] stab_cnt_r;
	logic [iss_pkg::STAB_W-1:0] stab_lim_r;
	logic [iss_pkg::STAB_W-1:0] stab_lim_nxt;
	logic trig;
	logic wake_any;
	logic higher;
	logic standby;
	logic [7:0] rdata_nxt;

	assign trig = reg_wr && (reg_addr == iss_pkg::ADDR_TRIG) &&
		reg_wdata[iss_pkg::TRIG_BIT];
	// Maskable requests are already unmasked by the interrupt controller.
	assign wake_any = wake_in.nmi | wake_in.ext_irq |
		wake_in.int_irq;
	assign higher = wake_in.nmi || !in_service ||
		(wake_in.prio < service_prio);
	assign standby = (state_r == iss_pkg::ISS_IDLE) ||
		(state_r == iss_pkg::ISS_STOP);

	always_comb begin
		stab_lim_nxt = '0;
		// A one-hot limit keeps the end test a plain compare of the counter.
		stab_lim_nxt[iss_pkg::STAB_EXP_BASE +
			32'(stab_sel_r)] = 1'b1;
	end

	// Registers survive standby untouched; only srst loads their reset values.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_r <= iss_pkg::MODE_RST;
			stab_sel_r <= iss_pkg::STAB_RST;
			clksel_r <= iss_pkg::CLKSEL_RST;
		end else if (reg_wr && state_r == iss_pkg::ISS_RUN) begin
			case (reg_addr)
				iss_pkg::ADDR_MODE: mode_r <= reg_wdata;
				iss_pkg::ADDR_STAB: stab_sel_r <= reg_wdata[2:0];
				iss_pkg::ADDR_CLKSEL: clksel_r <= reg_wdata;
				default: mode_r <= mode_r;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= iss_pkg::ISS_RUN;
			stab_cnt_r <= '0;
			stab_lim_r <= '0;
		end else begin
			case (state_r)
				iss_pkg::ISS_RUN: begin
					if (trig) begin
						if (mode_r[iss_pkg::MODE_DEEP_BIT])
							state_r <= iss_pkg::ISS_STOP;
						else
							state_r <= iss_pkg::ISS_IDLE;
					end
				end
				iss_pkg::ISS_IDLE: begin
					if (wake_any)
						state_r <= iss_pkg::ISS_RUN;
				end
				iss_pkg::ISS_STOP: begin
					if (wake_any) begin
						state_r <= iss_pkg::ISS_STAB;
						stab_cnt_r <= '0;
						stab_lim_r <= stab_lim_nxt;
					end
				end
				iss_pkg::ISS_STAB: begin
					stab_cnt_r <= stab_cnt_r + 1'b1;
					if (stab_cnt_r + 1'b1 >= stab_lim_r)
						state_r <= iss_pkg::ISS_RUN;
				end
				default: state_r <= iss_pkg::ISS_RUN;
			endcase
		end
	end

	// Wake result: pulse, acknowledge and branch decision.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wake_pulse <= 1'b0;
			wake_ack <= 1'b0;
			wake_branch <= 1'b0;
		end else begin
			wake_pulse <= standby && wake_any;
			wake_ack <= standby && wake_any && higher;
			wake_branch <= standby && wake_any && higher &&
				(wake_in.nmi || int_enable);
		end
	end

	// The oscillator restarts as soon as a wake leaves deep stop, so it can
	// settle while the CPU and peripherals still wait with their clocks off.
	assign main_osc_en = !(state_r == iss_pkg::ISS_STOP);
	assign cpu_clk_en = (state_r == iss_pkg::ISS_RUN);
	assign periph_clk_en = (state_r == iss_pkg::ISS_RUN);
	assign intc_clk_en = (state_r == iss_pkg::ISS_RUN);
	assign port_hold = standby;

	always_comb begin
		keep_en.timer8 = !standby || clksel_r[iss_pkg::SEL_T8_EXT];
		keep_en.serial = !standby || clksel_r[iss_pkg::SEL_SER_EXT];
		keep_en.uart0 = !standby || clksel_r[iss_pkg::SEL_UART_EXT];
		if (!standby)
			keep_en.watch = 1'b1;
		else if (clksel_r[iss_pkg::SEL_SUB_USED])
			keep_en.watch = clksel_r[iss_pkg::SEL_WT_SUB] ||
				state_r == iss_pkg::ISS_IDLE;
		else
			keep_en.watch = state_r == iss_pkg::ISS_IDLE &&
				clksel_r[iss_pkg::SEL_WT_MAIN];
		keep_en.th2 = !standby || (clksel_r[iss_pkg::SEL_SUB_USED] &&
			clksel_r[iss_pkg::SEL_TH2_SUB]);
		keep_en.wd2 = !standby || (clksel_r[iss_pkg::SEL_SUB_USED] &&
			clksel_r[iss_pkg::SEL_WD2_SUB]);
		keep_en.key = 1'b1;
	end

	assign mode_state = state_r;

	always_comb begin
		rdata_nxt = '0;
		case (reg_addr)
			iss_pkg::ADDR_MODE: rdata_nxt = mode_r;
			iss_pkg::ADDR_STAB: rdata_nxt = {5'h00, stab_sel_r};
			iss_pkg::ADDR_CLKSEL: rdata_nxt = clksel_r;
			iss_pkg::ADDR_STAT: rdata_nxt = {6'h00, state_r};
			default: rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= '0;
	end

	property p_idle_entry;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_RUN && trig &&
			!mode_r[iss_pkg::MODE_DEEP_BIT] |=> state_r == iss_pkg::ISS_IDLE;
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("no idle");
	property p_stop_entry;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_RUN && trig &&
			mode_r[iss_pkg::MODE_DEEP_BIT] |=> !main_osc_en;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("no stop");
	property p_idle_exit;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_IDLE && wake_any |=>
			cpu_clk_en && wake_pulse;
	endproperty
	a_idle_exit: assert property (p_idle_exit)
		else $error("idle exit");
	property p_idle_osc;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_IDLE |-> main_osc_en && !cpu_clk_en;
	endproperty
	a_idle_osc: assert property (p_idle_osc)
		else $error("idle clocks");
	property p_stab_wait;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STOP && wake_any |=> !cpu_clk_en [*8];
	endproperty
	a_stab_wait: assert property (p_stab_wait)
		else $error("short wait");
	property p_low_prio;
		@(posedge core_clk) disable iff (srst)
		standby && wake_any && in_service && !wake_in.nmi &&
			wake_in.prio >= service_prio |=> wake_pulse && !wake_ack;
	endproperty
	a_low_prio: assert property (p_low_prio) else $error("low acked");
	property p_nmi_branch;
		@(posedge core_clk) disable iff (srst)
		standby && wake_in.nmi |=> wake_ack && wake_branch;
	endproperty
	a_nmi_branch: assert property (p_nmi_branch) else $error("nmi");
	property p_di_cont;
		@(posedge core_clk) disable iff (srst)
		!int_enable && !wake_in.nmi |=> !wake_branch;
	endproperty
	a_di_cont: assert property (p_di_cont) else $error("di branch");
	property p_port_hold;
		@(posedge core_clk) disable iff (srst)
		$rose(standby) |-> port_hold && !periph_clk_en && keep_en.key;
	endproperty
	a_port_hold: assert property (p_port_hold) else $error("ports");
	c_idle: cover property (@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_IDLE ##1 state_r == iss_pkg::ISS_RUN);
	c_stop: cover property (@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STAB ##1 state_r == iss_pkg::ISS_RUN);
	c_low: cover property (@(posedge core_clk) disable iff (srst)
		wake_pulse && !wake_ack);
	c_branch: cover property (@(posedge core_clk) disable iff (srst)
		wake_ack && wake_branch);
	c_stab_busy: cover property (@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STAB && stab_cnt_r == 16'h0080);

	// Clock gating per state: only the run state feeds the CPU.
	property p_stop_clocks;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STOP |-> !main_osc_en && !cpu_clk_en &&
			!periph_clk_en && !intc_clk_en && port_hold;
	endproperty
	a_stop_clocks: assert property (p_stop_clocks)
		else $error("stop clocks");

	property p_run_clocks;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_RUN |-> main_osc_en && cpu_clk_en &&
			periph_clk_en && intc_clk_en && !port_hold;
	endproperty
	a_run_clocks: assert property (p_run_clocks)
		else $error("run clocks");

	property p_stab_osc;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STAB |-> main_osc_en && !cpu_clk_en &&
			!periph_clk_en;
	endproperty
	a_stab_osc: assert property (p_stab_osc)
		else $error("stab clocks");

	// The settling wait must neither end early nor overrun its limit.
	property p_stab_count;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STAB && stab_cnt_r + 1'b1 < stab_lim_r |=>
			state_r == iss_pkg::ISS_STAB;
	endproperty
	a_stab_count: assert property (p_stab_count)
		else $error("stab ended early");

	property p_stab_exit;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STAB && stab_cnt_r + 1'b1 >= stab_lim_r |=>
			state_r == iss_pkg::ISS_RUN && cpu_clk_en;
	endproperty
	a_stab_exit: assert property (p_stab_exit)
		else $error("stab overran");

	property p_stab_limit;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STOP && wake_any |=> stab_cnt_r == '0 &&
			$onehot(stab_lim_r) &&
			stab_lim_r[iss_pkg::STAB_EXP_BASE + 32'(stab_sel_r)];
	endproperty
	a_stab_limit: assert property (p_stab_limit)
		else $error("stab limit");

	property p_regs_held;
		@(posedge core_clk) disable iff (srst)
		standby |=> $stable(mode_r) && $stable(stab_sel_r) &&
			$stable(clksel_r);
	endproperty
	a_regs_held: assert property (p_regs_held)
		else $error("registers changed in standby");

	// No disable here: this one checks what reset itself leaves behind.
	property p_reset_run;
		@(posedge core_clk)
		srst |=> state_r == iss_pkg::ISS_RUN && main_osc_en && !wake_pulse &&
			mode_r == iss_pkg::MODE_RST && stab_sel_r == iss_pkg::STAB_RST &&
			clksel_r == iss_pkg::CLKSEL_RST;
	endproperty
	a_reset_run: assert property (p_reset_run)
		else $error("reset state");

	property p_keep_ext;
		@(posedge core_clk) disable iff (srst)
		standby |-> keep_en.key &&
			keep_en.timer8 == clksel_r[iss_pkg::SEL_T8_EXT] &&
			keep_en.serial == clksel_r[iss_pkg::SEL_SER_EXT] &&
			keep_en.uart0 == clksel_r[iss_pkg::SEL_UART_EXT];
	endproperty
	a_keep_ext: assert property (p_keep_ext)
		else $error("external clock keep");

	property p_keep_sub;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_STOP |->
			keep_en.watch == (clksel_r[iss_pkg::SEL_SUB_USED] &&
			clksel_r[iss_pkg::SEL_WT_SUB]) &&
			keep_en.th2 == (clksel_r[iss_pkg::SEL_SUB_USED] &&
			clksel_r[iss_pkg::SEL_TH2_SUB]) &&
			keep_en.wd2 == (clksel_r[iss_pkg::SEL_SUB_USED] &&
			clksel_r[iss_pkg::SEL_WD2_SUB]);
	endproperty
	a_keep_sub: assert property (p_keep_sub)
		else $error("subclock keep");

	property p_idle_watch;
		@(posedge core_clk) disable iff (srst)
		state_r == iss_pkg::ISS_IDLE |->
			keep_en.watch == (clksel_r[iss_pkg::SEL_SUB_USED] ||
			clksel_r[iss_pkg::SEL_WT_MAIN]);
	endproperty
	a_idle_watch: assert property (p_idle_watch)
		else $error("idle watch");

	// Wake results only ever come out of a standby state.
	property p_pulse_standby;
		@(posedge core_clk) disable iff (srst)
		!standby |=> !wake_pulse && !wake_ack && !wake_branch;
	endproperty
	a_pulse_standby: assert property (p_pulse_standby)
		else $error("wake outside standby");

	property p_high_ack;
		@(posedge core_clk) disable iff (srst)
		standby && wake_any && !wake_in.nmi && (!in_service ||
			wake_in.prio < service_prio) |=> wake_pulse && wake_ack;
	endproperty
	a_high_ack: assert property (p_high_ack)
		else $error("high not acked");

	property p_ei_branch;
		@(posedge core_clk) disable iff (srst)
		standby && wake_any && !in_service && int_enable |=> wake_branch;
	endproperty
	a_ei_branch: assert property (p_ei_branch)
		else $error("no branch");
endmodule // iss_ctrl
`default_nettype wire

// >>> inc/iss_pkg.sv
// Package for the idle/stop standby controller: register map, field
// positions, reset values, timing constants, state enum and carriers.
// Assumes a single 25 MHz core clock and a plain strobe register port.
`default_nettype none
package iss_pkg;
	localparam int CLK_HZ = 25000000;
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_TRIG = 4'h1;
	localparam logic [3:0] ADDR_STAB = 4'h2;
	localparam logic [3:0] ADDR_CLKSEL = 4'h3;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam int MODE_DEEP_BIT = 0;
	localparam int TRIG_BIT = 1;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [2:0] STAB_RST = 3'h7;
	localparam logic [7:0] CLKSEL_RST = 8'h00;
	localparam int SEL_T8_EXT = 0;
	localparam int SEL_SER_EXT = 1;
	localparam int SEL_UART_EXT = 2;
	localparam int SEL_WT_MAIN = 3;
	localparam int SEL_WT_SUB = 4;
	localparam int SEL_TH2_SUB = 5;
	localparam int SEL_WD2_SUB = 6;
	localparam int SEL_SUB_USED = 7;
	localparam int STAB_EXP_BASE = 8;
	localparam int STAB_EXP_RST = 15;
	localparam int STAB_W = 16;
	localparam logic [2:0] PRIO_NMI = 3'h0;
	typedef enum logic [1:0] {
		ISS_RUN,
		ISS_IDLE,
		ISS_STOP,
		ISS_STAB
	} iss_state_t;
	typedef struct packed {
		logic nmi;
		logic ext_irq;
		logic int_irq;
		logic [2:0] prio;
	} iss_wake_t;
	typedef struct packed {
		logic timer8;
		logic serial;
		logic uart0;
		logic watch;
		logic th2;
		logic wd2;
		logic key;
	} iss_keep_t;
endpackage
`default_nettype wire

// >>> verif/iss_cpu_model.sv
// CPU and interrupt controller stand-in that raises one wake request.
// Assumes the bench pulses go for one cycle; the request is held until
// the controller answers with a wake pulse.
`default_nettype none
module iss_cpu_model (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic go,
	input wire logic [1:0] kind,
	input wire logic [2:0] prio,
	input wire logic wake_pulse,
	output var iss_pkg::iss_wake_t wake_in
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge core_clk) begin
		if (srst) begin
			wake_in <= '0;
		end else if (go) begin
			wake_in <= {kind == 2'h0, kind == 2'h1, kind == 2'h2, prio};
		end else if (wake_pulse) begin
			wake_in <= '0;
		end
	end
endmodule // iss_cpu_model
`default_nettype wire

// >>> verif/idle_stop_standby_control_bench.sv
// Self-checking bench for the standby controller.
// Assumes the package and the CPU model are compiled first.
`default_nettype none
module idle_stop_standby_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic in_service = 1'b0, int_enable = 1'b0, go = 1'b0, ack;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, sel, obs, want, wres;
	logic [2:0] service_prio = 3'h0, prio = 3'h0;
	logic [1:0] kind = 2'h0, mode_state;
	logic wake_ack, wake_branch, wake_pulse, main_osc_en, cpu_clk_en;
	logic periph_clk_en, intc_clk_en, port_hold, deep, nmi;
	logic [31:0] r;
	iss_pkg::iss_wake_t wake_in;
	iss_pkg::iss_keep_t keep_en;
	logic [7:0] rq[$];
	logic [7:0] wq[$];
	int failures = 0, total_checks = 0, n;
	iss_ctrl i_dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .wake_in, .in_service, .service_prio, .int_enable,
		.wake_ack, .wake_branch, .wake_pulse, .main_osc_en, .cpu_clk_en,
		.periph_clk_en, .intc_clk_en, .keep_en, .port_hold, .mode_state);
	iss_cpu_model i_cpu (.core_clk, .srst, .go, .kind, .prio, .wake_pulse,
		.wake_in);
	assign wres = {6'h00, wake_ack, wake_branch};
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// A gap cycle after each strobe keeps one assignment per time step.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_st(input logic [1:0] s);
		n = 0;
		while (mode_state !== s && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 2000) begin
			failures++;
			end_of_test();
		end
	endtask
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1) cmp(reg_rdata, rq.pop_front());
		if (wake_pulse === 1'b1)
			cmp(wres, wq.pop_front());
	end
	initial begin
		r = $urandom(38);
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rd(iss_pkg::ADDR_MODE, iss_pkg::MODE_RST);
		rd(iss_pkg::ADDR_STAB, {5'h00, iss_pkg::STAB_RST});
		rd(iss_pkg::ADDR_CLKSEL, iss_pkg::CLKSEL_RST);
		rd(4'hF, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			sel = $urandom();
			deep = i > 2;
			wr(iss_pkg::ADDR_STAB, 8'(i % 3));
			wr(iss_pkg::ADDR_CLKSEL, sel);
			wr(iss_pkg::ADDR_MODE, {7'h00, deep});
			wr(iss_pkg::ADDR_TRIG, 8'h02);
			repeat (5) @(posedge core_clk);
			obs = {main_osc_en, cpu_clk_en, periph_clk_en, intc_clk_en,
				port_hold, mode_state, 1'b0};
			want = {!deep, 4'b0001, deep, !deep, 1'b0};
			cmp(obs, want);
			obs = {keep_en.timer8, keep_en.serial, keep_en.uart0, keep_en.key,
				4'h0};
			want = {sel[0], sel[1], sel[2], 5'h10};
			cmp(obs, want);
			obs = {keep_en.watch, keep_en.th2, keep_en.wd2, 5'h00};
			want = {sel[7] ? sel[4] || !deep : !deep && sel[3],
				sel[7] && sel[5], sel[7] && sel[6], 5'h00};
			cmp(obs, want);
			// Writes in standby must be refused, so the mode bit survives.
			wr(iss_pkg::ADDR_MODE, {7'h00, !deep});
			rd(iss_pkg::ADDR_CLKSEL, sel);
			rd(iss_pkg::ADDR_STAT, {6'h00, deep, !deep});
			r = $urandom();
			// Tests 1 and 4 force a serviced level so both priority outcomes
			// of a maskable wake are seen whatever the random draw.
			in_service <= r[0] || i == 1 || i == 4;
			int_enable <= r[1];
			service_prio <= i == 1 ? 3'h0 : i == 4 ? 3'h7 : r[4:2];
			prio <= i == 4 ? 3'h0 : r[7:5];
			kind <= 2'(i % 3);
			go <= 1'b1;
			@(posedge core_clk);
			go <= 1'b0;
			nmi = kind == 2'h0;
			ack = nmi | !in_service | (prio < service_prio);
			wq.push_back({6'h00, ack, nmi | (int_enable & ack)});
			if (deep) begin
				wait_st(2'h3);
				wait_st(2'h0);
				want = {7'h00, n == (1 << (iss_pkg::STAB_EXP_BASE + i % 3))};
				cmp(want, 8'h01);
			end else begin
				wait_st(2'h0);
				cmp(8'(n), 8'h02);
			end
			rd(iss_pkg::ADDR_MODE, {7'h00, deep});
			$display("test wake %0d done", i);
		end
		// Reset is released out of deep stop, with the oscillator off.
		wr(iss_pkg::ADDR_MODE, 8'h01);
		wr(iss_pkg::ADDR_TRIG, 8'h02);
		repeat (5) @(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		obs = {main_osc_en, cpu_clk_en, periph_clk_en, intc_clk_en,
			port_hold, mode_state, 1'b0};
		cmp(obs, 8'hF0);
		rd(iss_pkg::ADDR_MODE, iss_pkg::MODE_RST);
		rd(iss_pkg::ADDR_STAB, {5'h00, iss_pkg::STAB_RST});
		$display("test reset release done");
		end_of_test();
	end
endmodule // idle_stop_standby_control_bench
`default_nettype wire
